// *** inc/upc_pkg.sv ***
/*
  upc_pkg: constants and carrier types for the usb phy common test
  register bank.
  assumes: one 40 MHz clock, synchronous active-high reset.
*/
package upc_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [15:0] UPC_REGION_BASE  = 16'h1200;
  localparam logic [11:0] UPC_OFS_COMMON   = 12'h000;
  localparam logic [11:0] UPC_OFS_U2_TEST  = 12'h0C4;
  localparam logic [11:0] UPC_OFS_U2_UPSTR = 12'h0C8;

  // ****************************************************
  // field positions of phy_common_test_ctrl
  // ****************************************************
  localparam int UPC_B_CLK_DIS    = 31;
  localparam int UPC_B_PATH_SEL   = 24;
  localparam int UPC_B_XTAL_GAIN  = 23;
  localparam int UPC_B_REF_FREQ   = 19;
  localparam int UPC_B_CORE_POR   = 18;
  localparam int UPC_B_LPM        = 17;
  localparam int UPC_B_HS_PLL_EN  = 16;
  localparam int UPC_B_COM_SUSP_N = 15;
  localparam int UPC_B_XTAL_SUSP_N = 14;
  localparam int UPC_B_PLL_USABLE = 12;
  localparam int UPC_B_SS_PLL_EN  = 11;
  localparam int UPC_B_SS_USABLE  = 10;
  localparam int UPC_B_TMR_DIS    = 9;
  localparam int UPC_B_GATE_BYP   = 0;

  // writable bits mask and reset values
  localparam logic [31:0] UPC_WR_MASK   = 32'h818BCA01;
  localparam logic [31:0] UPC_RST_CTRL  = 32'h00010000;
  localparam logic [31:0] UPC_RST_AFE   = 32'h00000000;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } upc_bus_s;

  typedef struct packed {
    logic clock_disable;
    logic common_test_path_select;
    logic crystal_gain_select;
    logic pll_reference_freq_select;
    logic pll_fast_start_lpm;
    logic hs_pll_enable;
    logic common_suspend_n;
    logic crystal_suspend_n;
    logic ss_tx_pll_enable;
    logic analog_ready_timer_disable;
    logic clock_gating_bypass;
  } upc_ctrl_s;

  typedef struct packed {
    logic core_supply_por_ready;
    logic pll_clocks_usable;
    logic ss_tx_pll_usable;
  } upc_stat_s;

endpackage : upc_pkg

// *** hdl/upc_regs.sv ***
/*
  upc_regs: common block test register of the usb phy plus two
  plain storage words for the usb 2.0 analog registers.
  assumes: master never waits, read data one cycle after read strobe,
  status inputs and default strap come from other clock domains.
*/
// Design decision made here: the plain strobed port.
// Notes on behaviour
// - common register at 000h, analog at 0C4h/0C8h.
// - bit 31 gates common block register clock.
// - bit 24 selects functional or test signals.
// - bit 23 selects crystal drive amplitude.
// - bit 19 picks 25 or 24 MHz.
// - bit 18 shows core supply por ready.
// - bit 17 enables fast pll startup.
// - bit 17 soft reset default from nonvolatile flag; sys_rst clears it.
// - bit 16 enables usb2 pll, resets high.
// - low bit 15 suspends bias and pll.
// - low bit 14 suspends crystal block.
// - bit 12 reports pll clocks usable.
// - bit 11 ss pll enable, bit 10 usable.
// - bit 9 disables analog ready timer.
// - bit 0 forces clock gating bypass.
module upc_regs (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              lite_reset,
  input  wire logic              usb_reset,
  input  wire upc_pkg::upc_bus_s bus,
  output logic [31:0]            rdata,
  input  wire upc_pkg::upc_stat_s stat_async,
  input  wire logic              lpm_default,
  output upc_pkg::upc_ctrl_s     ctrl,
  output logic [31:0]            usb2_analog_test_ctrl,
  output logic [31:0]            usb2_analog_upstream_ctrl
);
  import upc_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [31:0] com;
    logic [31:0] afe_test;
    logic [31:0] afe_up;
    logic [31:0] rdata;
    upc_stat_s   sync1;
    upc_stat_s   sync2;
    logic        lpm1;
    logic        lpm2;
  } upc_state_s;

  upc_state_s st_ff;
  upc_state_s nxt_st;
  logic       soft_rst;
  logic [31:0] com_rd;

  assign soft_rst = lite_reset | usb_reset;

  always_comb begin
    com_rd = st_ff.com & UPC_WR_MASK;
    com_rd[UPC_B_CORE_POR]   = st_ff.sync2.core_supply_por_ready;
    com_rd[UPC_B_PLL_USABLE] = st_ff.sync2.pll_clocks_usable;
    com_rd[UPC_B_SS_USABLE]  = st_ff.sync2.ss_tx_pll_usable;
  end

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = stat_async;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.lpm1  = lpm_default;
    nxt_st.lpm2  = st_ff.lpm1;
    nxt_st.rdata = 32'h00000000;
    if (bus.rd) begin
      unique case (bus.addr)
        UPC_OFS_COMMON:   nxt_st.rdata = com_rd;
        UPC_OFS_U2_TEST:  nxt_st.rdata = st_ff.afe_test;
        UPC_OFS_U2_UPSTR: nxt_st.rdata = st_ff.afe_up;
        default:          nxt_st.rdata = 32'h00000000;
      endcase
    end
    // writes to reserved offsets are dropped
    if (bus.wr) begin
      unique case (bus.addr)
        UPC_OFS_COMMON:   nxt_st.com = bus.wdata & UPC_WR_MASK;
        UPC_OFS_U2_TEST:  nxt_st.afe_test = bus.wdata;
        UPC_OFS_U2_UPSTR: nxt_st.afe_up = bus.wdata;
        default:          nxt_st.com = st_ff.com;
      endcase
    end
    if (soft_rst) begin
      nxt_st.com = UPC_RST_CTRL;
      nxt_st.com[UPC_B_LPM] = st_ff.lpm2;
      nxt_st.afe_test = UPC_RST_AFE;
      nxt_st.afe_up   = UPC_RST_AFE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.com <= UPC_RST_CTRL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************
  // control outputs
  // ****************************************************
  assign rdata = st_ff.rdata;
  assign usb2_analog_test_ctrl     = st_ff.afe_test;
  assign usb2_analog_upstream_ctrl = st_ff.afe_up;
  assign ctrl.clock_disable = st_ff.com[UPC_B_CLK_DIS];
  assign ctrl.common_test_path_select = st_ff.com[UPC_B_PATH_SEL];
  assign ctrl.crystal_gain_select = st_ff.com[UPC_B_XTAL_GAIN];
  assign ctrl.pll_reference_freq_select = st_ff.com[UPC_B_REF_FREQ];
  assign ctrl.pll_fast_start_lpm = st_ff.com[UPC_B_LPM];
  assign ctrl.hs_pll_enable = st_ff.com[UPC_B_HS_PLL_EN];
  assign ctrl.common_suspend_n = st_ff.com[UPC_B_COM_SUSP_N];
  assign ctrl.crystal_suspend_n = st_ff.com[UPC_B_XTAL_SUSP_N];
  assign ctrl.ss_tx_pll_enable = st_ff.com[UPC_B_SS_PLL_EN];
  assign ctrl.analog_ready_timer_disable = st_ff.com[UPC_B_TMR_DIS];
  assign ctrl.clock_gating_bypass = st_ff.com[UPC_B_GATE_BYP];

endmodule : upc_regs

// *** test/upc_chk_properties.sv ***
/* upc_chk: port checks on upc_regs; bound at the foot. */
module upc_chk (
  input logic               mclk,
  input logic               sys_rst,
  input logic               lite_reset,
  input logic               usb_reset,
  input upc_pkg::upc_bus_s  bus,
  input logic [31:0]        rdata,
  input upc_pkg::upc_ctrl_s ctrl
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence wr0;
    bus.wr && bus.addr == 12'h000 && !(lite_reset || usb_reset);
  endsequence
  property wf(f, int n);
    wr0 |=> f == $past(bus.wdata[n]);
  endproperty
  chk_clk_dis:
    assert property (wf(ctrl.clock_disable, 31)) else $error("bit 31");
  chk_path_sel:
    assert property (wf(ctrl.common_test_path_select, 24)) else $error("b24");
  chk_xtal_gain:
    assert property (wf(ctrl.crystal_gain_select, 23)) else $error("b23");
  chk_ref_freq:
    assert property (wf(ctrl.pll_reference_freq_select, 19)) else $error("b19");
  chk_ss_pll:
    assert property (wf(ctrl.ss_tx_pll_enable, 11)) else $error("bit 11");
  chk_gate_byp:
    assert property (wf(ctrl.clock_gating_bypass, 0)) else $error("bit 0");
  chk_soft_dflt: assert property ((lite_reset | usb_reset) |=>
    ctrl.hs_pll_enable && !ctrl.clock_disable) else $error("soft default");
  chk_rd_idle: assert property (!bus.rd |=> rdata == 32'h0)
    else $error("rdata not idle");
endmodule : upc_chk
bind upc_regs upc_chk upc_chk_inst (.*);

// *** test/usb_phy_common_test_regs_bench.sv ***
/* bench: random register traffic on upc_regs, queued reads. */
module usb_phy_common_test_regs_bench;
  timeunit 1ns / 100ps;
  import upc_pkg::*;
  logic        mclk = 0, sys_rst = 1, lite_reset = 0, usb_reset = 0;
  logic        lpm_default = 1, rd_d = 0;
  logic [31:0] rdata, s, d, q[$], usb2_analog_test_ctrl;
  logic [31:0] usb2_analog_upstream_ctrl;
  upc_bus_s    bus = '0;
  upc_stat_s   stat_async;
  upc_ctrl_s   ctrl;
  int          miscompares = 0, checked = 0, cyc = 0;
  wire [2:0]   st = stat_async;
  upc_regs upc_regs_inst (.*);
  always #12.5 mclk = ~mclk;
  task op(input logic [1:0] k, logic [11:0] a, logic [31:0] w, e);
    @(posedge mclk);
    bus <= '{k[1], k[0], a, w};
    if (k[0]) q.push_back(e);
  endtask : op
  task cmp(input logic [31:0] e, g);
    checked++;
    miscompares += int'(g !== e);
    if (g !== e) $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
  endtask : cmp
  task tally_and_finish(input int extra);
    miscompares += extra;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    rd_d <= bus.rd;
    if (rd_d) cmp(q.pop_front(), rdata);
    if (++cyc == 800) tally_and_finish(1);
  end
  initial begin
    stat_async = 3'($urandom(43));
    s = {13'h0, st[2], 5'h0, st[1], 1'b0, st[0], 10'h0};
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    op(2'b01, 12'h000, '0, UPC_RST_CTRL | s);
    op(2'b01, 12'h004, '0, '0);
    repeat (20) begin
      d = $urandom;
      op(2'b10, 12'h000, d, '0);
      op(2'b01, 12'h000, '0, (d & UPC_WR_MASK) | s);
      op(2'b10, 12'h0C4, ~d, '0);
      op(2'b01, 12'h0C4, '0, ~d);
      op(2'b10, 12'h0C8, d, '0);
      op(2'b01, 12'h0C8, '0, d);
    end
    for (int i = 0; i < 2; i++) begin
      op(2'b10, 12'h000, '1, '0);
      {usb_reset, lite_reset} <= i ? 2'b01 : 2'b10;
      op(2'b01, 12'h000, '0, 32'h00030000 | s);
      {usb_reset, lite_reset} <= 2'b00;
    end
    op(2'b00, 12'h000, '0, '0);
    repeat (3) @(posedge mclk);
    tally_and_finish(0);
  end
endmodule : usb_phy_common_test_regs_bench
